/* rtl/branch_predict_issue_control.sv */
// branch_predict_issue_control: line issue, scoreboard and branch redirect
// assumes: fetchLine answers fetchAddr in the same cycle; resolve refers to
// the line in the last pipeline stage; all inputs synchronous to sys_clk
`default_nettype none
module branch_predict_issue_control
   import bpic_pkg::*;
#(
   parameter int DEPTH = PIPE_DEPTH,
   parameter int BTB_N = BTB_ENTRIES
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire line_t fetchLine,
   input wire logic [15:0] condFlags,
   input wire logic [PC_W-1:0] jumpTarget,
   input wire resolve_t resolve,
   output logic [PC_W-1:0] fetchAddr,
   output line_t issueLine,
   output logic issueExec,
   output logic [PC_W-1:0] retAddr,
   output savereq_t saveReq,
   output line_t retireLine
);
   // refuse a pipeline too short to hold issue plus one stage
   if (DEPTH < 2)
   begin : badDepth
      $error("branch_predict_issue_control: DEPTH must be at least 2");
   end

   // ************************************************************
   // state
   // ************************************************************
   typedef struct packed {
      logic [PC_W-1:0] pc; // fetch address
      logic [2:0] penalty; // lost cycles still to wait
      logic [PC_W-1:0] link; // return address of last call
      logic [NREG-1:0][1:0] busy; // cycles until register usable
      logic [NREG-1:0] byIalu; // pending result from integer unit
      line_t issued; // line issued last cycle
      logic exec; // issued line passes its condition
      savereq_t save; // save request of issued line
   } st_t;
   st_t st_reg; // current state
   st_t st_next; // next state

   // decode results
   logic hazard; // some source not yet usable
   logic brFound; // line holds a branch slot
   op_t brOp; // class of that branch
   logic brPred; // its static prediction bit
   logic [IMM_W-1:0] brImm; // its relative offset
   logic brTaken; // redirect predicted
   logic [PC_W-1:0] brTarget; // target when buffer misses
   logic condHit; // line has a condition slot
   logic [3:0] condSel; // its flag selector
   logic saveHit; // line holds a save slot
   logic [4:0] saveReg; // first register to save
   logic [3:0] saveCnt; // registers to save, clamped
   slot_t sl; // slot under decode
   logic ialuUse; // slot is an integer unit operation
   logic mispredict; // wrong path detected
   logic fire; // line accepted this cycle
   logic btbHit; // buffer holds target of fetch line
   logic [PC_W-1:0] btbTarget; // that target
   logic btbWr; // install target after miss

   // ************************************************************
   // decode and dependency check
   // ************************************************************
   // scan the four slots of the fetched line
   always_comb
   begin
      hazard = 1'b0;
      brFound = 1'b0;
      brOp = OP_NOP;
      brPred = 1'b0;
      brImm = '0;
      condHit = 1'b0;
      condSel = '0;
      saveHit = 1'b0;
      saveReg = '0;
      saveCnt = '0;
      sl = '0;
      ialuUse = 1'b0;
      for (int s = 0; s < SLOTS; s++)
      begin
         sl = fetchLine.slot[s];
         ialuUse = (sl.op == OP_INTEGER_ADDRESS_ALU);
         if (sl.op != OP_NOP)
         begin
            if (st_reg.busy[sl.srcA] != 2'h0 && (!st_reg.byIalu[sl.srcA] || ialuUse))
            begin
               hazard = 1'b1;
            end
            if (st_reg.busy[sl.srcB] != 2'h0 && (!st_reg.byIalu[sl.srcB] || ialuUse))
            begin
               hazard = 1'b1;
            end
         end
         // first branch slot decides the redirect
         if (!brFound && sl.op inside {OP_JUMP, OP_CALL, OP_RET, OP_RTI, OP_CJMP})
         begin
            brFound = 1'b1;
            brOp = sl.op;
            brPred = sl.predTaken;
            brImm = sl.imm;
         end
         if (sl.condEn)
         begin
            condHit = 1'b1;
            condSel = sl.condSel;
         end
         if (sl.op == OP_SAVE)
         begin
            saveHit = 1'b1;
            saveReg = sl.dst;
            saveCnt = (sl.imm[3:0] > 4'(MAX_SAVE)) ? 4'(MAX_SAVE) : sl.imm[3:0];
         end
      end
   end

   // returns and computed jumps always redirect
   always_comb
   begin
      brTaken = brFound && ((brOp == OP_JUMP || brOp == OP_CALL) ? brPred : 1'b1);
      unique case (brOp)
         OP_JUMP, OP_CALL: brTarget = fetchAddr + {{(PC_W-IMM_W){brImm[IMM_W-1]}}, brImm};
         OP_RET, OP_RTI: brTarget = st_reg.link;
         OP_CJMP: brTarget = jumpTarget;
         default: brTarget = fetchAddr;
      endcase
   end

   assign mispredict = resolve.valid && resolve.mispredict;
   assign fire = fetchLine.valid && !hazard && st_reg.penalty == 3'h0 && !mispredict;
   assign btbWr = fire && brTaken && !btbHit;

   // ************************************************************
   // branch target buffer
   // ************************************************************
   // lookup at the fetch address, write after a miss
   btb_buffer #(.ENTRIES(BTB_N)) u_btb (
      .sys_clk(sys_clk),
      .rstn(rstn),
      .lookPc(st_reg.pc),
      .hit(btbHit),
      .target(btbTarget),
      .wrEn(btbWr),
      .wrPc(st_reg.pc),
      .wrTarget(brTarget)
   );

   // ************************************************************
   // next state
   // ************************************************************
   always_comb
   begin
      st_next = st_reg;
      st_next.issued.valid = 1'b0;
      st_next.save.valid = 1'b0;
      // count down pending results
      for (int r = 0; r < NREG; r++)
      begin
         if (st_reg.busy[r] != 2'h0)
         begin
            st_next.busy[r] = st_reg.busy[r] - 2'h1;
         end
      end
      if (mispredict)
      begin
         st_next.pc = resolve.target;
         st_next.penalty = 3'(MISP_MIN) + {1'b0, resolve.condKind};
      end
      else if (st_reg.penalty != 3'h0)
      begin
         // lost cycles while the redirect settles
         st_next.penalty = st_reg.penalty - 3'h1;
      end
      else if (fire)
      begin
         st_next.issued = fetchLine;
         st_next.exec = !condHit || condFlags[condSel];
         st_next.save.valid = saveHit;
         st_next.save.firstReg = saveReg;
         st_next.save.blk0Words = (saveCnt > 4'(BLK_WORDS)) ? 4'(BLK_WORDS) : saveCnt;
         st_next.save.blk1Words = (saveCnt > 4'(BLK_WORDS)) ? saveCnt - 4'(BLK_WORDS) : 4'h0;
         for (int s = 0; s < SLOTS; s++)
         begin
            unique case (fetchLine.slot[s].op)
               OP_INTEGER_ADDRESS_ALU:
               begin
                  st_next.busy[fetchLine.slot[s].dst] = 2'(INTEGER_ADDRESS_ALU_DEP_LAT - INTEGER_ADDRESS_ALU_LAT);
                  st_next.byIalu[fetchLine.slot[s].dst] = 1'b1;
               end
               OP_COMP:
               begin
                  st_next.busy[fetchLine.slot[s].dst] = 2'(COMP_LAT - 1);
                  st_next.byIalu[fetchLine.slot[s].dst] = 1'b0;
               end
               OP_MOVE:
               begin
                  st_next.busy[fetchLine.slot[s].dst] = 2'(MOVE_LAT - 1);
                  st_next.byIalu[fetchLine.slot[s].dst] = 1'b0;
               end
               default:
               begin
               end
            endcase
         end
         // call keeps return address in register
         if (brFound && brOp == OP_CALL && brTaken)
         begin
            st_next.link = st_reg.pc + PC_W'(1);
         end
         if (brTaken && btbHit)
         begin
            st_next.pc = btbTarget;
         end
         else if (brTaken)
         begin
            st_next.pc = brTarget;
            st_next.penalty = 3'(BTB_MISS_PEN);
         end
         else
         begin
            st_next.pc = st_reg.pc + PC_W'(1);
         end
      end
   end

   // state register
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
         st_reg.pc <= RESET_PC;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign fetchAddr = st_reg.pc;
   assign issueLine = st_reg.issued;
   assign issueExec = st_reg.exec;
   assign retAddr = st_reg.link;
   assign saveReq = st_reg.save;

   // ************************************************************
   // pipeline stages after issue
   // ************************************************************
   line_t stageQ [DEPTH-1]; // stage outputs
   logic [DEPTH-2:0] stageValid; // stage occupancy
   for (genvar k = 0; k < DEPTH - 1; k++)
   begin : gStage
      pipe_stage u_stage (
         .sys_clk(sys_clk),
         .rstn(rstn),
         .flush(mispredict),
         .d((k == 0) ? st_reg.issued : stageQ[(k == 0) ? 0 : k - 1]),
         .q(stageQ[k])
      );
      assign stageValid[k] = stageQ[k].valid;
   end
   assign retireLine = stageQ[DEPTH-2];

   // ************************************************************
   // assertions
   // ************************************************************
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (!rstn);

   line_issue_a:
      assert property (fire |=> issueLine == $past(fetchLine))
      else $error("accepted line not issued whole");
   issue_rate_a:
      assert property (fetchLine.valid && !hazard && st_reg.penalty == 3'h0
         && !mispredict |=> issueLine.valid)
      else $error("ready line not issued");
   comp_lat_a:
      assert property (fire && fetchLine.slot[0].op == OP_COMP
         |=> st_reg.busy[$past(fetchLine.slot[0].dst)] == 2'(COMP_LAT - 1))
      else $error("compute latency wrong");
   integer_address_alu_dep_a:
      assert property (fire && fetchLine.slot[0].op == OP_INTEGER_ADDRESS_ALU
         |=> st_reg.byIalu[$past(fetchLine.slot[0].dst)]
         && st_reg.busy[$past(fetchLine.slot[0].dst)] == 2'(INTEGER_ADDRESS_ALU_DEP_LAT - 1))
      else $error("integer chain latency wrong");
   move_lat_a:
      assert property (fire && fetchLine.slot[0].op == OP_MOVE
         |=> st_reg.busy[$past(fetchLine.slot[0].dst)] == 2'(MOVE_LAT - 1))
      else $error("move latency wrong");
   btb_miss_a:
      assert property (btbWr |=> ##1 (!issueLine.valid)[*2])
      else $error("buffer miss penalty wrong");
   btb_hit_a:
      assert property (fire && brTaken && btbHit
         |=> fetchAddr == $past(btbTarget) && st_reg.penalty == 3'h0)
      else $error("buffer hit not used next cycle");
   misp_pen_a:
      assert property (mispredict |=> st_reg.penalty == 3'(MISP_MIN)
         + {1'b0, $past(resolve.condKind)} && st_reg.penalty <= 3'(MISP_MAX))
      else $error("misprediction penalty wrong");
   flush_a:
      assert property (mispredict |=> !issueLine.valid && stageValid == '0
         && fetchAddr == $past(resolve.target))
      else $error("wrong path not cancelled");
   stall_a:
      assert property (fetchLine.valid && hazard && st_reg.penalty == 3'h0 && !mispredict
         |=> !issueLine.valid && $stable(fetchAddr))
      else $error("dependency did not stall");
   link_a:
      assert property (fire && brTaken && brOp == OP_CALL
         |=> retAddr == $past(fetchAddr) + PC_W'(1))
      else $error("return address not kept");
   save_a:
      assert property (saveReq.valid |-> saveReq.blk0Words <= 4'(BLK_WORDS)
         && saveReq.blk1Words <= 4'(BLK_WORDS))
      else $error("save exceeds block width");
   cond_a:
      assert property (fire && !condHit |=> issueExec)
      else $error("unconditional line suppressed");

   hit_c: cover property (fire && brTaken && btbHit);
   miss_c: cover property (btbWr ##4 issueLine.valid);
   misp_c: cover property (mispredict && resolve.condKind == 2'h3);
   stall_c: cover property ((fetchLine.valid && hazard) [*2]);
endmodule // branch_predict_issue_control
`default_nettype wire

/* rtl/bpic_pkg.sv */
// package: types and constants shared by the issue and branch control
// assumes: one core clock, instruction lines of four 32-bit slots
`default_nettype none
package bpic_pkg;
   // ************************************************************
   // sizes
   // ************************************************************
   localparam int SLOTS = 4; // slots per instruction line
   localparam int PC_W = 16; // fetch address width in lines
   localparam int NREG = 32; // scoreboarded registers
   localparam int IMM_W = 7; // immediate field width
   localparam int PIPE_DEPTH = 8; // pipeline stages
   localparam int BTB_ENTRIES = 16; // target buffer entries
   localparam int MAX_SAVE = 8; // registers saved per cycle
   localparam int BLK_WORDS = 4; // words per memory block per cycle

   // ************************************************************
   // cycle counts and reset values
   // ************************************************************
   localparam int INTEGER_ADDRESS_ALU_LAT = 1; // integer result to normal consumer
   localparam int COMP_LAT = 2; // compute result latency
   localparam int INTEGER_ADDRESS_ALU_DEP_LAT = 3; // integer result to integer consumer
   localparam int MOVE_LAT = 2; // register move, memory load timing
   localparam int BTB_MISS_PEN = 2; // predicted taken, buffer miss
   localparam int MISP_MIN = 3; // least misprediction penalty
   localparam int MISP_MAX = 6; // largest misprediction penalty
   localparam logic [PC_W-1:0] RESET_PC = 16'h0000; // fetch start

   // ************************************************************
   // types
   // ************************************************************
   // slot operation classes
   typedef enum logic [3:0] {
      OP_NOP, OP_INTEGER_ADDRESS_ALU, OP_COMP, OP_MOVE, OP_SAVE,
      OP_JUMP, OP_CALL, OP_RET, OP_RTI, OP_CJMP
   } op_t;

   // one 32-bit instruction slot
   typedef struct packed {
      op_t op; // operation class
      logic [4:0] dst; // destination or first saved register
      logic [4:0] srcA; // first source
      logic [4:0] srcB; // second source
      logic predTaken; // program marks jump as usually taken
      logic condEn; // this slot carries the line condition
      logic [3:0] condSel; // condition flag selector
      logic [IMM_W-1:0] imm; // branch offset or save count
   } slot_t;

   // one instruction line
   typedef struct packed {
      logic valid; // line present
      logic [PC_W-1:0] pc; // line address
      slot_t [SLOTS-1:0] slot; // up to four slots
   } line_t;

   // branch outcome from the last pipeline stage
   typedef struct packed {
      logic valid; // outcome present
      logic mispredict; // static prediction was wrong
      logic [1:0] condKind; // kind of conditional execution
      logic [PC_W-1:0] target; // correct continuation address
   } resolve_t;

   // multi-register save over two memory blocks
   typedef struct packed {
      logic valid; // request present
      logic [4:0] firstReg; // first register saved
      logic [3:0] blk0Words; // words to block 0
      logic [3:0] blk1Words; // words to block 1
   } savereq_t;
endpackage : bpic_pkg
`default_nettype wire

/* rtl/pipe_stage.sv */
// pipe_stage: one register stage of the instruction pipeline
// assumes: flush is high for one cycle and kills the incoming line
`default_nettype none
module pipe_stage
   import bpic_pkg::*;
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic flush,
   input wire line_t d,
   output var line_t q
);
   // stage state
   typedef struct packed {
      line_t line; // held line
   } stage_t;
   stage_t st_reg; // current stage content
   stage_t st_next; // next stage content

   // take the line from the previous stage unless cancelled
   always_comb
   begin
      st_next.line = d;
      if (flush)
      begin
         st_next.line.valid = 1'b0;
      end
   end

   // stage register
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign q = st_reg.line;
endmodule // pipe_stage
`default_nettype wire

/* rtl/btb_buffer.sv */
// btb_buffer: direct-mapped branch target buffer
// assumes: lookup is combinational on the fetch address, writes land next edge
`default_nettype none
module btb_buffer
   import bpic_pkg::*;
#(
   parameter int ENTRIES = BTB_ENTRIES
)
(
   input wire logic sys_clk,
   input wire logic rstn,
   input wire logic [PC_W-1:0] lookPc,
   output logic hit,
   output logic [PC_W-1:0] target,
   input wire logic wrEn,
   input wire logic [PC_W-1:0] wrPc,
   input wire logic [PC_W-1:0] wrTarget
);
   localparam int IW = $clog2(ENTRIES); // index width

   // refuse sizes that the direct index cannot serve
   if (ENTRIES < 2 || (ENTRIES & (ENTRIES - 1)) != 0 || ENTRIES > 2 ** PC_W)
   begin : badEntries
      $error("btb_buffer: ENTRIES must be a power of two");
   end

   // buffer state
   typedef struct packed {
      logic [ENTRIES-1:0] valid; // entry holds a target
      logic [ENTRIES-1:0][PC_W-1:0] tag; // jump line address
      logic [ENTRIES-1:0][PC_W-1:0] dest; // stored target
   } btb_t;
   btb_t st_reg; // current buffer
   btb_t st_next; // buffer after write

   // tag compare at the fetch address
   always_comb
   begin
      hit = st_reg.valid[lookPc[IW-1:0]] && st_reg.tag[lookPc[IW-1:0]] == lookPc;
      target = st_reg.dest[lookPc[IW-1:0]];
   end

   // install a new target, replacing whatever shares the index
   always_comb
   begin
      st_next = st_reg;
      if (wrEn)
      begin
         st_next.valid[wrPc[IW-1:0]] = 1'b1;
         st_next.tag[wrPc[IW-1:0]] = wrPc;
         st_next.dest[wrPc[IW-1:0]] = wrTarget;
      end
   end

   // buffer register, empty after reset
   always_ff @(posedge sys_clk or negedge rstn)
   begin
      if (!rstn)
      begin
         st_reg <= '0;
      end
      else
      begin
         st_reg <= st_next;
      end
   end
endmodule // btb_buffer
`default_nettype wire

/* dv/imem_model.sv */
// imem_model: on-chip instruction memory answering the fetch address
// assumes: the bench loads prog at time zero, before reset is released
`default_nettype none
module imem_model
   import bpic_pkg::*;
(
   input wire logic [PC_W-1:0] fetchAddr,
   output line_t fetchLine,
   output logic [PC_W-1:0] jumpTarget
);
   timeunit 1ns;
   timeprecision 1ns;
   line_t prog [64]; // program lines, address wraps every 64 lines
   // ************************************************************
   // fetch answer
   // ************************************************************
   // answers in the same cycle; a line is always present
   always_comb
   begin
      fetchLine = prog[fetchAddr[5:0]];
      fetchLine.valid = 1'b1;
      fetchLine.pc = fetchAddr;
   end
   // computed jumps land on the idle loop
   assign jumpTarget = 16'h0020;
endmodule // imem_model
`default_nettype wire

/* dv/tb.sv */
// tb: issue, stall, branch and flush scenarios on the issue control
// assumes: imem_model serves fetches; the bench drives on the falling edge
`default_nettype none
module tb;
   import bpic_pkg::*;
   timeunit 1ns;
   timeprecision 1ns;
   logic sys_clk = 1'b0;
   logic rstn = 1'b0;
   logic [15:0] condFlags = 16'h0008; // only flag 3 set
   resolve_t resolve = '0;
   line_t fetchLine, issueLine, retireLine;
   logic [PC_W-1:0] fetchAddr, jumpTarget, retAddr;
   logic issueExec;
   savereq_t saveReq;
   int error_cnt = 0;
   int checks_done = 0;
   int n; // cycles waited for the last issue
   int base; // flush wait with the least penalty
   always #25 sys_clk = ~sys_clk;
   imem_model i_imem_model (.fetchAddr(fetchAddr), .fetchLine(fetchLine),
      .jumpTarget(jumpTarget));
   branch_predict_issue_control i_branch_predict_issue_control (.sys_clk(sys_clk),
      .rstn(rstn), .fetchLine(fetchLine), .condFlags(condFlags), .jumpTarget(jumpTarget),
      .resolve(resolve), .fetchAddr(fetchAddr), .issueLine(issueLine),
      .issueExec(issueExec), .retAddr(retAddr), .saveReq(saveReq), .retireLine(retireLine));
   // ************************************************************
   // helpers
   // ************************************************************
   // builds a line: slot 0 as given, slot 3 a compute nobody reads
   function automatic line_t mk(op_t op, logic [4:0] d, logic [4:0] s, logic [4:0] c,
      logic [6:0] imm);
      mk = '0;
      mk.slot[0] = '{op, d, s, 5'h00, op inside {OP_JUMP, OP_CALL}, c[4], c[3:0], imm};
      mk.slot[3].op = OP_COMP;
      mk.slot[3].dst = 5'h14;
   endfunction
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      checks_done++;
      if (exp !== got)
      begin
         error_cnt++;
         $display("unexpected %s: expected %0h, seen %0h", what, exp, got);
      end
   endtask
   task automatic chk_line(string what, line_t exp, line_t got);
      checks_done++;
      if (exp !== got)
      begin
         error_cnt++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic end_of_test;
      $display("checks %0d, errors %0d", checks_done, error_cnt);
      if (error_cnt == 0 && checks_done > 0)
         $display("SIMULATION PASSED");
      else
         $display("SIMULATION FAILED");
      $finish;
   endtask
   // counts cycles to the issue of pc; strict flags any other issue
   task automatic wait_pc(logic [15:0] pc, bit strict);
      n = 0;
      repeat (40)
      begin
         @(posedge sys_clk);
         #1;
         n++;
         if (issueLine.valid === 1'b1 && issueLine.pc === pc)
            return;
         if (strict && issueLine.valid !== 1'b0)
            chk("stray issue", 32'h0, 32'h1);
      end
      error_cnt++;
      $display("unexpected issue of %0h: expected within 40, seen none", pc);
      end_of_test();
   endtask
   // ************************************************************
   // scenarios
   // ************************************************************
   // first pass: stalls, buffer misses, condition and save
   task automatic t_stream;
      line_t e;
      e = i_imem_model.prog[0];
      e.valid = 1'b1;
      wait_pc(16'h0000, 1'b0);
      chk_line("line 0", e, issueLine);
      wait_pc(16'h0001, 1'b0);
      chk("gap plain", 32'd1, n);
      wait_pc(16'h0002, 1'b0);
      chk("gap move", 32'd2, n);
      wait_pc(16'h0003, 1'b0);
      chk("gap compute", 32'd2, n);
      wait_pc(16'h0004, 1'b0);
      wait_pc(16'h0005, 1'b0);
      chk("gap integer", 32'd3, n);
      wait_pc(16'h0006, 1'b0);
      chk("jump target", 32'h000a, fetchAddr);
      wait_pc(16'h000a, 1'b0);
      chk("gap miss", 32'd3, n);
      chk("exec on", 32'h1, issueExec);
      wait_pc(16'h000b, 1'b0);
      chk("exec off", 32'h0, issueExec);
      wait_pc(16'h000c, 1'b0);
      chk("save valid", 32'h1, saveReq.valid);
      chk("save first", 32'h4, saveReq.firstReg);
      chk("save blk0", 32'h4, saveReq.blk0Words);
      chk("save blk1", 32'h4, saveReq.blk1Words);
      // the save line leaves the last stage seven edges after issue
      e = i_imem_model.prog[12];
      e.valid = 1'b1;
      e.pc = 16'h000c;
      repeat (PIPE_DEPTH - 1) @(posedge sys_clk);
      #1;
      chk_line("retire line", e, retireLine);
   endtask
   // second pass: both jumps now sit in the buffer
   task automatic t_hit;
      wait_pc(16'h0006, 1'b0);
      wait_pc(16'h000a, 1'b0);
      chk("gap hit fwd", 32'd1, n);
      wait_pc(16'h000d, 1'b0);
      wait_pc(16'h0000, 1'b0);
      chk("gap hit back", 32'd1, n);
   endtask
   // one misprediction, restarting fetch at tgt
   task automatic t_flush(logic [1:0] k, logic [15:0] tgt);
      @(negedge sys_clk);
      resolve = '{1'b1, 1'b1, k, tgt};
      @(negedge sys_clk);
      resolve = '0;
      chk("flush addr", {16'h0000, tgt}, fetchAddr);
      chk("flush retire", 32'h0, retireLine.valid);
      chk("flush issue", 32'h0, issueLine.valid);
      wait_pc(tgt, 1'b1);
   endtask
   // penalty grows by one cycle per conditional kind
   task automatic t_misp;
      t_flush(2'd0, 16'h0020);
      t_flush(2'd0, 16'h0020);
      base = n;
      for (int k = 1; k < 4; k++)
      begin
         t_flush(k[1:0], 16'h0020);
         chk("misp penalty", k, n - base);
      end
   endtask
   // call, return and computed jump: buffer miss first, hit second
   task automatic t_call;
      for (int p = 0; p < 2; p++)
      begin
         t_flush(2'd0, 16'h0030);
         chk("link addr", 32'h31, retAddr);
         wait_pc(16'h0034, 1'b1);
         chk("gap call", (p == 0) ? 32'd3 : 32'd1, n);
         chk("ret target", 32'h31, fetchAddr);
         wait_pc(16'h0031, 1'b1);
         chk("gap return", (p == 0) ? 32'd3 : 32'd1, n);
         chk("cjmp target", 32'h20, fetchAddr);
         wait_pc(16'h0020, 1'b1);
         chk("gap cjmp", (p == 0) ? 32'd3 : 32'd1, n);
      end
   endtask
   // ************************************************************
   // main sequence
   // ************************************************************
   initial
   begin
      for (int i = 0; i < 64; i++)
         i_imem_model.prog[i] = mk(OP_NOP, 5'h00, 5'h00, 5'h00, 7'h00);
      i_imem_model.prog[1] = mk(OP_MOVE, 5'h08, 5'h00, 5'h00, 7'h00);
      i_imem_model.prog[2] = mk(OP_COMP, 5'h05, 5'h08, 5'h00, 7'h00);
      i_imem_model.prog[3] = mk(OP_INTEGER_ADDRESS_ALU, 5'h07, 5'h05, 5'h00, 7'h00);
      i_imem_model.prog[4] = mk(OP_INTEGER_ADDRESS_ALU, 5'h06, 5'h00, 5'h00, 7'h00);
      i_imem_model.prog[5] = mk(OP_INTEGER_ADDRESS_ALU, 5'h07, 5'h06, 5'h00, 7'h00);
      i_imem_model.prog[6] = mk(OP_JUMP, 5'h00, 5'h00, 5'h00, 7'h04);
      i_imem_model.prog[10] = mk(OP_NOP, 5'h00, 5'h00, 5'h13, 7'h00);
      i_imem_model.prog[11] = mk(OP_NOP, 5'h00, 5'h00, 5'h12, 7'h00);
      i_imem_model.prog[12] = mk(OP_SAVE, 5'h04, 5'h00, 5'h00, 7'h08);
      i_imem_model.prog[13] = mk(OP_JUMP, 5'h00, 5'h00, 5'h00, 7'h73);
      i_imem_model.prog[40] = mk(OP_JUMP, 5'h00, 5'h00, 5'h00, 7'h78);
      i_imem_model.prog[48] = mk(OP_CALL, 5'h00, 5'h00, 5'h00, 7'h04);
      i_imem_model.prog[49] = mk(OP_CJMP, 5'h00, 5'h00, 5'h00, 7'h00);
      i_imem_model.prog[52] = mk(OP_RET, 5'h00, 5'h00, 5'h00, 7'h00);
      repeat (12) @(posedge sys_clk);
      @(negedge sys_clk);
      rstn = 1'b1;
      t_stream();
      t_hit();
      t_misp();
      t_call();
      end_of_test();
   end
endmodule // tb
`default_nettype wire
